//--- hw/lcd_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_clk_div
   import lcd_pkg::*;
#(
   parameter int CNT_W = 18
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // source ticks, already on clk_in
   input wire logic xt_tick_in,
   input wire logic prs_tick_in,
   input wire logic rl_tick_in,
   // selection
   input wire logic [2:0] src_sel_in,
   input wire logic [2:0] div_sel_in,
   // divided clock tick
   output logic slot_tick_out
);
   if (CNT_W < 18) begin
      $error("lcd_clk_div: CNT_W too small");
   end

   logic [CNT_W-1:0] prs_cnt_reg, prs_cnt_next;
   logic [2:0] rl_cnt_reg, rl_cnt_next;
   logic [9:0] lcd_cnt_reg, lcd_cnt_next;
   logic slot_tick_reg, slot_tick_next;
   logic src_tick;
   logic [3:0] exp;

   // ---------------------------------------------
   // source and divided clock
   // ---------------------------------------------
   always_comb begin
      prs_cnt_next = prs_cnt_reg;
      rl_cnt_next = rl_cnt_reg;
      lcd_cnt_next = lcd_cnt_reg;
      slot_tick_next = 1'b0;
      src_tick = 1'b0;
      exp = 4'(LCD_DIV_BASE_EXP) + {1'b0, div_sel_in};
      if (prs_tick_in) prs_cnt_next = prs_cnt_reg + 1'b1;
      if (rl_tick_in) rl_cnt_next = rl_cnt_reg + 1'b1;
      case (src_sel_in) // RULE15
         LCD_SRC_XT: src_tick = xt_tick_in;
         LCD_SRC_PRS6: src_tick = prs_tick_in && (prs_cnt_reg[5:0] == 6'h3F);
         LCD_SRC_PRS7: src_tick = prs_tick_in && (prs_cnt_reg[6:0] == 7'h7F);
         LCD_SRC_PRS8: src_tick = prs_tick_in && (prs_cnt_reg[7:0] == 8'hFF);
         LCD_SRC_RL3: src_tick = rl_tick_in && (rl_cnt_reg == 3'h7);
         default: src_tick = 1'b0;
      endcase
      if (src_tick && (div_sel_in <= LCD_DIV_MAX_CODE)) begin // RULE16
         lcd_cnt_next = lcd_cnt_reg + 1'b1;
         if ((lcd_cnt_reg & ((10'h001 << exp) - 10'h001)) == ((10'h001 << exp) - 10'h001))
            slot_tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prs_cnt_reg <= '0;
         rl_cnt_reg <= 3'h0;
         lcd_cnt_reg <= 10'h000;
         slot_tick_reg <= 1'b0;
      end else begin
         prs_cnt_reg <= prs_cnt_next;
         rl_cnt_reg <= rl_cnt_next;
         lcd_cnt_reg <= lcd_cnt_next;
         slot_tick_reg <= slot_tick_next;
      end
   end

   assign slot_tick_out = slot_tick_reg;
endmodule
`default_nettype wire

//--- hw/lcd_ctrl.sv
// Functional notes
// RULE1: drive generator mode register at FFB0, bit or byte writes, resets to 00.
// RULE2: bits 5:4 pick external, internal, or internal step-down division; others prohibited.
// RULE3: software writes zero to unused drive generator bits.
// RULE4: display mode control register at FFB1, bit or byte writes, resets to 00.
// RULE5: display off holds every segment at deselect; on shows memory.
// RULE6: pin control 0 grounds all pins; 1 gives deselect segments and common waveform.
// RULE7: bit 4 turns gate voltage boosting on or off.
// RULE8: bits 2:0 choose 8, 4, 3, 2, 3 slices or static with bias.
// RULE9: software writes zero to bits 3 and 5 of display mode.
// RULE10: 22 segments and 8 commons; low segments, high commons share pins.
// RULE11: upper four commons act only in eight-slice mode.
// RULE12: quarter bias turns shared pin into fourth reference input.
// RULE13: software should clear pin control and boost when display unused.
// RULE14: clock select register at FFB2, bit or byte writes, resets to 00.
// RULE15: bits 6:4 pick subsystem, divided peripheral, or divided low-speed clock.
// RULE16: bits 2:0 divide source by 2^4 up to 2^9.
// RULE17: software writes zero to bits 3 and 7 of clock select.
// RULE18: frame rate follows divided clock and slice count.
// RULE19: one common slot per divided clock period.
// RULE20: 22 data bytes at FA40; bit n is read in slot n. Code reads bits 0 to 3 only; segments stay at deselect in slots 4 to 7.
// RULE21: static mode drives same common signal on commons 0 to 3.
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl
   import lcd_pkg::*;
#(
   parameter int NUM_SEG = LCD_NUM_SEG,
   parameter int NUM_COM = LCD_NUM_COM
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // memory access port
   input wire lcd_bus_req_t bus_req_in,
   output logic [7:0] bus_rdata_out,
   output logic bus_hit_out,
   // clock sources, from other domains
   input wire logic xt_clk_in,
   input wire logic prs_tick_in,
   input wire logic rl_clk_in,
   // segment pins
   output lcd_level_t [NUM_SEG-1:0] segment_level_out,
   output logic [NUM_SEG-1:0] segment_oe_out,
   // common pins
   output lcd_level_t [NUM_COM-1:0] common_level_out,
   output logic [NUM_COM-1:0] common_oe_out,
   // analog and shared pin control
   output logic [1:0] voltage_method_out,
   output logic gate_boost_en_out,
   output logic fourth_ref_sel_out,
   output logic frame_start_out
);
   if (NUM_SEG != LCD_NUM_SEG || NUM_COM != LCD_NUM_COM) begin
      $error("lcd_ctrl: unsupported pin counts");
   end

   function automatic lcd_mode_info_t mode_info(input logic [2:0] code);
      lcd_mode_info_t m;
      m = '{slices: 3'h4, last_slot: 3'h3, is_static: 1'b0, bias_quarter: 1'b0, legal: 1'b1};
      case (code)
         LCD_MODE_8SLICE: m = '{3'h0, 3'h7, 1'b0, 1'b1, 1'b1};
         LCD_MODE_4SLICE: m = '{3'h4, 3'h3, 1'b0, 1'b0, 1'b1};
         LCD_MODE_3SLICE_B3: m = '{3'h3, 3'h2, 1'b0, 1'b0, 1'b1};
         LCD_MODE_2SLICE: m = '{3'h2, 3'h1, 1'b0, 1'b0, 1'b1};
         LCD_MODE_3SLICE_B2: m = '{3'h3, 3'h2, 1'b0, 1'b0, 1'b1};
         LCD_MODE_STATIC: m = '{3'h1, 3'h0, 1'b1, 1'b0, 1'b1};
         default: m.legal = 1'b0;
      endcase
      return m;
   endfunction

   // merge bit or byte write into a register
   function automatic logic [7:0] merge_wr(input logic [7:0] old, input lcd_bus_req_t r, input logic [7:0] mask);
      logic [7:0] v;
      v = r.bit_op ? ((old & ~(8'h01 << r.bit_sel)) | ({7'h00, r.wdata[0]} << r.bit_sel)) : r.wdata;
      return v & mask;
   endfunction

   // ---------------------------------------------
   // clock synchronisers
   // ---------------------------------------------
   logic xt_s1_reg, xt_s2_reg, xt_s3_reg;
   logic rl_s1_reg, rl_s2_reg, rl_s3_reg;
   logic prs_s1_reg, prs_s2_reg;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         {xt_s1_reg, xt_s2_reg, xt_s3_reg} <= 3'h0;
         {rl_s1_reg, rl_s2_reg, rl_s3_reg} <= 3'h0;
         {prs_s1_reg, prs_s2_reg} <= 2'h0;
      end else begin
         xt_s1_reg <= xt_clk_in;
         xt_s2_reg <= xt_s1_reg;
         xt_s3_reg <= xt_s2_reg;
         rl_s1_reg <= rl_clk_in;
         rl_s2_reg <= rl_s1_reg;
         rl_s3_reg <= rl_s2_reg;
         prs_s1_reg <= prs_tick_in;
         prs_s2_reg <= prs_s1_reg;
      end
   end

   logic [7:0] clk_sel_reg, clk_sel_next;
   logic slot_tick;
   lcd_clk_div u_div (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .xt_tick_in(xt_s2_reg & ~xt_s3_reg),
      .prs_tick_in(prs_s2_reg),
      .rl_tick_in(rl_s2_reg & ~rl_s3_reg),
      .src_sel_in(clk_sel_reg[LCD_POS_SRC_SEL +: 3]),
      .div_sel_in(clk_sel_reg[2:0]),
      .slot_tick_out(slot_tick)
   );

   // ---------------------------------------------
   // registers and display memory
   // ---------------------------------------------
   logic [7:0] drive_gen_reg, drive_gen_next;
   logic [7:0] disp_mode_reg, disp_mode_next;
   logic [7:0] data_mem [NUM_SEG];
   logic [7:0] rdata_reg, rdata_next;
   logic hit_reg, hit_next;
   logic data_hit;
   logic [4:0] data_idx;

   always_comb begin
      drive_gen_next = drive_gen_reg;
      disp_mode_next = disp_mode_reg;
      clk_sel_next = clk_sel_reg;
      data_idx = 5'(bus_req_in.addr - LCD_ADDR_DATA_FIRST);
      data_hit = (bus_req_in.addr >= LCD_ADDR_DATA_FIRST) && (bus_req_in.addr <= LCD_ADDR_DATA_LAST);
      rdata_next = 8'h00;
      hit_next = 1'b0;
      case (bus_req_in.addr)
         LCD_ADDR_DRIVE_GEN: begin
            hit_next = bus_req_in.wr | bus_req_in.rd;
            rdata_next = drive_gen_reg;
            if (bus_req_in.wr) drive_gen_next = merge_wr(drive_gen_reg, bus_req_in, LCD_DRIVE_GEN_MASK); // RULE1 RULE3
         end
         LCD_ADDR_DISP_MODE: begin
            hit_next = bus_req_in.wr | bus_req_in.rd;
            rdata_next = disp_mode_reg;
            if (bus_req_in.wr) disp_mode_next = merge_wr(disp_mode_reg, bus_req_in, LCD_DISP_MODE_MASK); // RULE4 RULE9
         end
         LCD_ADDR_CLK_SEL: begin
            hit_next = bus_req_in.wr | bus_req_in.rd;
            rdata_next = clk_sel_reg;
            if (bus_req_in.wr) clk_sel_next = merge_wr(clk_sel_reg, bus_req_in, LCD_CLK_SEL_MASK); // RULE14 RULE17
         end
         default: begin
            hit_next = data_hit & (bus_req_in.wr | bus_req_in.rd);
            rdata_next = data_hit ? data_mem[data_idx] : 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         drive_gen_reg <= LCD_RESET_VALUE;
         disp_mode_reg <= LCD_RESET_VALUE;
         clk_sel_reg <= LCD_RESET_VALUE;
         rdata_reg <= 8'h00;
         hit_reg <= 1'b0;
      end else begin
         drive_gen_reg <= drive_gen_next;
         disp_mode_reg <= disp_mode_next;
         clk_sel_reg <= clk_sel_next;
         rdata_reg <= rdata_next;
         hit_reg <= hit_next;
      end
   end

   // display memory, plain RAM with no reset
   always_ff @(posedge clk_in) begin
      if (bus_req_in.wr && data_hit) // RULE20
         data_mem[data_idx] <= merge_wr(data_mem[data_idx], bus_req_in, 8'hFF);
   end

   // ---------------------------------------------
   // slot sequencer
   // ---------------------------------------------
   lcd_mode_info_t mode;
   logic [2:0] slot_reg, slot_next;
   logic phase_reg, phase_next;
   logic frame_reg, frame_next;
   logic disp_on, pin_en;

   always_comb begin
      mode = mode_info(disp_mode_reg[2:0]); // RULE8
      disp_on = disp_mode_reg[LCD_BIT_DISPLAY_ON];
      pin_en = disp_mode_reg[LCD_BIT_PIN_OUTPUT_CTRL];
      slot_next = slot_reg;
      phase_next = phase_reg;
      frame_next = 1'b0;
      if (slot_tick && mode.legal) begin // RULE19
         if (slot_reg >= mode.last_slot) begin // RULE18
            slot_next = 3'h0;
            phase_next = ~phase_reg;
            frame_next = 1'b1;
         end else begin
            slot_next = slot_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         slot_reg <= 3'h0;
         phase_reg <= 1'b0;
         frame_reg <= 1'b0;
      end else begin
         slot_reg <= slot_next;
         phase_reg <= phase_next;
         frame_reg <= frame_next;
      end
   end

   // ---------------------------------------------
   // pin levels
   // ---------------------------------------------
   lcd_level_t [NUM_SEG-1:0] seg_next, seg_reg;
   lcd_level_t [NUM_COM-1:0] com_next, com_reg;
   logic [NUM_SEG-1:0] seg_oe_reg;
   logic [NUM_COM-1:0] com_oe_next, com_oe_reg;
   lcd_level_t sel_lvl;

   always_comb begin
      sel_lvl = phase_reg ? LCD_LVL_SEL_B : LCD_LVL_SEL_A;
      com_oe_next = {NUM_COM{1'b1}};
      for (int s = 0; s < NUM_SEG; s++) begin
         seg_next[s] = LCD_LVL_GND; // RULE6
         if (pin_en) begin
            seg_next[s] = LCD_LVL_DESEL;
            if (disp_on && data_mem[s][slot_reg[1:0]] && slot_reg < 3'h4) seg_next[s] = sel_lvl; // RULE5 RULE20
         end
      end
      for (int c = 0; c < NUM_COM; c++) begin
         com_next[c] = LCD_LVL_GND; // RULE6
         if (pin_en) begin
            com_next[c] = LCD_LVL_DESEL;
            if (mode.is_static && c < 4) com_next[c] = sel_lvl; // RULE21
            else if (slot_reg == 3'(c)) com_next[c] = sel_lvl;
         end
         if (c >= 4 && !mode.bias_quarter) begin // RULE10 RULE11
            com_next[c] = LCD_LVL_GND;
            com_oe_next[c] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         seg_reg <= '{default: LCD_LVL_GND};
         com_reg <= '{default: LCD_LVL_GND};
         seg_oe_reg <= '0;
         com_oe_reg <= '0;
         voltage_method_out <= LCD_VM_EXTERNAL;
         gate_boost_en_out <= 1'b0;
         fourth_ref_sel_out <= 1'b0;
         frame_start_out <= 1'b0;
      end else begin
         seg_reg <= seg_next;
         com_reg <= com_next;
         seg_oe_reg <= {NUM_SEG{1'b1}};
         com_oe_reg <= com_oe_next;
         voltage_method_out <= drive_gen_reg[LCD_POS_VMETHOD +: 2]; // RULE2
         gate_boost_en_out <= disp_mode_reg[LCD_BIT_GATE_BOOST]; // RULE7 RULE13
         fourth_ref_sel_out <= mode.bias_quarter; // RULE12
         frame_start_out <= frame_reg;
      end
   end

   assign segment_level_out = seg_reg;
   assign common_level_out = com_reg;
   assign segment_oe_out = seg_oe_reg;
   assign common_oe_out = com_oe_reg;
   assign bus_rdata_out = rdata_reg;
   assign bus_hit_out = hit_reg;
endmodule
`default_nettype wire

//--- hw/lcd_pkg.sv
package lcd_pkg;
   // ---------------------------------------------
   // register map
   // ---------------------------------------------
   localparam logic [15:0] LCD_ADDR_DRIVE_GEN = 16'hFFB0;
   localparam logic [15:0] LCD_ADDR_DISP_MODE = 16'hFFB1;
   localparam logic [15:0] LCD_ADDR_CLK_SEL = 16'hFFB2;
   localparam logic [15:0] LCD_ADDR_DATA_FIRST = 16'hFA40;
   localparam logic [15:0] LCD_ADDR_DATA_LAST = 16'hFA55;
   localparam logic [7:0] LCD_RESET_VALUE = 8'h00;
   localparam logic [7:0] LCD_DRIVE_GEN_MASK = 8'h30;
   localparam logic [7:0] LCD_DISP_MODE_MASK = 8'hD7;
   localparam logic [7:0] LCD_CLK_SEL_MASK = 8'h77;
   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int LCD_BIT_DISPLAY_ON = 7;
   localparam int LCD_BIT_PIN_OUTPUT_CTRL = 6;
   localparam int LCD_BIT_GATE_BOOST = 4;
   localparam int LCD_POS_VMETHOD = 4;
   localparam int LCD_POS_SRC_SEL = 4;
   localparam int LCD_DIV_BASE_EXP = 4;
   localparam int LCD_NUM_SEG = 22;
   localparam int LCD_NUM_COM = 8;
   // ---------------------------------------------
   // codes
   // ---------------------------------------------
   localparam logic [1:0] LCD_VM_EXTERNAL = 2'h0;
   localparam logic [1:0] LCD_VM_INT_NOSTEP = 2'h1;
   localparam logic [1:0] LCD_VM_INT_STEP = 2'h2;
   localparam logic [2:0] LCD_MODE_8SLICE = 3'h7;
   localparam logic [2:0] LCD_MODE_4SLICE = 3'h0;
   localparam logic [2:0] LCD_MODE_3SLICE_B3 = 3'h1;
   localparam logic [2:0] LCD_MODE_2SLICE = 3'h2;
   localparam logic [2:0] LCD_MODE_3SLICE_B2 = 3'h3;
   localparam logic [2:0] LCD_MODE_STATIC = 3'h4;
   localparam logic [2:0] LCD_SRC_XT = 3'h0;
   localparam logic [2:0] LCD_SRC_PRS6 = 3'h1;
   localparam logic [2:0] LCD_SRC_PRS7 = 3'h2;
   localparam logic [2:0] LCD_SRC_PRS8 = 3'h3;
   localparam logic [2:0] LCD_SRC_RL3 = 3'h4;
   localparam logic [2:0] LCD_DIV_MAX_CODE = 3'h5;

   // ---------------------------------------------
   // bundles
   // ---------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic bit_op;
      logic [2:0] bit_sel;
   } lcd_bus_req_t;

   // pad drive per pin: drive level code only; output enables are separate vectors
   typedef enum logic [1:0] {LCD_LVL_GND, LCD_LVL_DESEL, LCD_LVL_SEL_A, LCD_LVL_SEL_B} lcd_level_t;

   typedef struct packed {
      logic [2:0] slices;
      logic [2:0] last_slot;
      logic is_static;
      logic bias_quarter;
      logic legal;
   } lcd_mode_info_t;
endpackage

//--- test/lcd_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_sva
   import lcd_pkg::*;
#(
   parameter int NUM_SEG = LCD_NUM_SEG,
   parameter int NUM_COM = LCD_NUM_COM
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // access port
   input wire lcd_bus_req_t bus_req_in,
   input wire logic [7:0] bus_rdata_out,
   input wire logic bus_hit_out,
   // pins
   input wire lcd_level_t [NUM_SEG-1:0] segment_level_out,
   input wire lcd_level_t [NUM_COM-1:0] common_level_out,
   input wire logic [NUM_COM-1:0] common_oe_out,
   input wire logic [1:0] voltage_method_out,
   input wire logic gate_boost_en_out,
   input wire logic fourth_ref_sel_out,
   input wire logic frame_start_out
);
   // ---------------------------------------------
   // shadow registers
   // ---------------------------------------------
   logic [7:0] dg_reg, dg_next, dm_reg, dm_next, dg_d1_reg, dg_d2_reg, dm_d1_reg, dm_d2_reg;
   logic acc, mapped, dg_calm, dm_calm;

   function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] msk, input lcd_bus_req_t r);
      logic [7:0] t;
      t = r.wdata;
      if (r.bit_op) begin
         t = cur;
         t[r.bit_sel] = r.wdata[0];
      end
      return t & msk;
   endfunction

   assign acc = bus_req_in.wr || bus_req_in.rd;
   assign mapped = bus_req_in.addr == 16'hFFB0 || bus_req_in.addr == 16'hFFB1 || bus_req_in.addr == 16'hFFB2 ||
      (bus_req_in.addr >= 16'hFA40 && bus_req_in.addr <= 16'hFA55);
   assign dg_calm = dg_reg == dg_d1_reg && dg_d1_reg == dg_d2_reg;
   assign dm_calm = dm_reg == dm_d1_reg && dm_d1_reg == dm_d2_reg;

   always_comb begin
      dg_next = dg_reg;
      dm_next = dm_reg;
      if (bus_req_in.wr && bus_req_in.addr == 16'hFFB0) begin
         dg_next = upd(dg_reg, 8'h30, bus_req_in);
      end
      if (bus_req_in.wr && bus_req_in.addr == 16'hFFB1) begin
         dm_next = upd(dm_reg, 8'hD7, bus_req_in);
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dg_reg <= 8'h00;
         dm_reg <= 8'h00;
         dg_d1_reg <= 8'h00;
         dg_d2_reg <= 8'h00;
         dm_d1_reg <= 8'h00;
         dm_d2_reg <= 8'h00;
      end else begin
         dg_reg <= dg_next;
         dm_reg <= dm_next;
         dg_d1_reg <= dg_reg;
         dg_d2_reg <= dg_d1_reg;
         dm_d1_reg <= dm_reg;
         dm_d2_reg <= dm_d1_reg;
      end
   end

   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   hit_on_map_a: assert property (acc && mapped |=> bus_hit_out)
      else $error("mapped access gave no hit");
   hit_quiet_a: assert property (!(acc && mapped) |=> !bus_hit_out)
      else $error("hit without mapped access");
   unmapped_zero_a: assert property (bus_req_in.rd && !mapped |=> bus_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   mode_readback_a: assert property (bus_req_in.rd && bus_req_in.addr == 16'hFFB1 |=>
      bus_rdata_out == $past(dm_reg))
      else $error("display mode readback wrong");
   vmethod_follow_a: assert property (dg_calm |-> voltage_method_out == dg_reg[5:4])
      else $error("voltage method output wrong");
   boost_follow_a: assert property (dm_calm |-> gate_boost_en_out == dm_reg[4])
      else $error("gate boost output wrong");
   quarter_ref_a: assert property (dm_calm |-> fourth_ref_sel_out == (dm_reg[2:0] == 3'h7))
      else $error("fourth reference select wrong");
   upper_com_a: assert property (dm_calm && dm_reg[2:0] != 3'h7 |->
      common_oe_out[NUM_COM-1:NUM_COM-4] == 4'h0)
      else $error("upper commons enabled outside eight slices");
   pins_ground_a: assert property (dm_calm && !dm_reg[6] |->
      segment_level_out == '0 && common_level_out == '0)
      else $error("pins not grounded");
   seg_deselect_a: assert property (dm_calm && dm_reg[6] && !dm_reg[7] |->
      segment_level_out == {NUM_SEG{LCD_LVL_DESEL}})
      else $error("segments not deselected with display off");
   static_common_a: assert property (dm_calm && dm_reg[6] && dm_reg[2:0] == 3'h4 |->
      common_level_out[1] == common_level_out[0] && common_level_out[2] == common_level_out[0] &&
      common_level_out[3] == common_level_out[0])
      else $error("static commons differ");
   frame_pulse_a: assert property (frame_start_out |=> !frame_start_out [*8])
      else $error("frame start too close");

   cover property (frame_start_out);
   cover property (common_oe_out[NUM_COM-1] && frame_start_out);
   cover property (dm_reg[7] && dm_reg[6] && frame_start_out);
endmodule
`default_nettype wire

//--- test/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
   import lcd_pkg::*;
#(
   parameter int NUM_SEG = LCD_NUM_SEG
) (
   // segment electrodes
   input wire lcd_level_t [NUM_SEG-1:0] segment_level_in,
   input wire logic [NUM_SEG-1:0] segment_oe_in,
   // driven segments at select level
   output logic [7:0] sel_count_out
);
   // passive panel: unknown drive stays visible in the count
   always_comb begin
      sel_count_out = 8'h00;
      for (int i = 0; i < NUM_SEG; i++) begin
         sel_count_out = sel_count_out + {7'h00, segment_oe_in[i] & segment_level_in[i][1]};
      end
   end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import lcd_pkg::*;
;
   logic clk_in = 1'b0;
   logic reset_n_in, xt_clk, rl_clk, prs_tick, hit, boost, quarter, frame;
   lcd_bus_req_t req;
   logic [7:0] rdata, sel_count;
   logic [1:0] vmeth;
   lcd_level_t [LCD_NUM_SEG-1:0] seg_lvl;
   logic [LCD_NUM_SEG-1:0] seg_oe;
   lcd_level_t [LCD_NUM_COM-1:0] com_lvl;
   logic [LCD_NUM_COM-1:0] com_oe;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   int n;
   logic [7:0] masks [3] = '{8'h30, 8'hD7, 8'h77};
   logic [2:0] modes [6] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
   int slices [6] = '{8, 4, 3, 2, 3, 1};
   int srcper [5] = '{8, 64, 128, 256, 96};

   lcd_ctrl DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_req_in(req), .bus_rdata_out(rdata),
      .bus_hit_out(hit), .xt_clk_in(xt_clk), .prs_tick_in(prs_tick), .rl_clk_in(rl_clk),
      .segment_level_out(seg_lvl), .segment_oe_out(seg_oe), .common_level_out(com_lvl), .common_oe_out(com_oe),
      .voltage_method_out(vmeth), .gate_boost_en_out(boost), .fourth_ref_sel_out(quarter),
      .frame_start_out(frame));
   lcd_panel_model panel (.segment_level_in(seg_lvl), .segment_oe_in(seg_oe), .sel_count_out(sel_count));

   always #2.5 clk_in = ~clk_in;
   initial begin
      xt_clk = 1'b0;
      #1;
      forever #20 xt_clk = ~xt_clk;
   end
   initial begin
      rl_clk = 1'b0;
      #2;
      forever #30 rl_clk = ~rl_clk;
   end

   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic chk(input string what, input logic [43:0] exp, input logic [43:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic req_go(input logic [15:0] a, input logic [7:0] d, input logic w, input logic bo,
      input logic [2:0] bs);
      @(posedge clk_in);
      #1 req = '{a, d, w, ~w, bo, bs};
      @(posedge clk_in);
      #1 req = '0;
   endtask

   task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp, input logic exp_hit);
      req_go(a, 8'h00, 1'b0, 1'b0, 3'h0);
      chk("read data", 44'(exp), 44'(rdata));
      chk("access hit", 44'(exp_hit), 44'(hit));
   endtask

   task automatic frame_len(output int len);
      len = 0;
      do begin
         @(posedge clk_in);
         #1 len++;
      end while (frame !== 1'b1 && len < 20000);
      len = 0;
      do begin
         @(posedge clk_in);
         #1 len++;
      end while (frame !== 1'b1 && len < 20000);
   endtask

   task automatic report_and_stop;
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      req = '0;
      prs_tick = 1'b1;
      reset_n_in = 1'b0;
      repeat (16) @(posedge clk_in);
      #1 reset_n_in = 1'b1;
      for (int i = 0; i < 3; i++) begin
         bus_rd(LCD_ADDR_DRIVE_GEN + 16'(i), 8'h00, 1'b1);
         req_go(LCD_ADDR_DRIVE_GEN + 16'(i), 8'hFF, 1'b1, 1'b0, 3'h0);
         bus_rd(LCD_ADDR_DRIVE_GEN + 16'(i), masks[i], 1'b1);
      end
      bus_rd(16'hFFB3, 8'h00, 1'b0);
      for (int v = 0; v < 3; v++) begin
         req_go(LCD_ADDR_DRIVE_GEN, 8'(v << 4), 1'b1, 1'b0, 3'h0);
         repeat (2) @(posedge clk_in);
         #1 chk("voltage method", 44'(v), 44'(vmeth));
      end
      req_go(LCD_ADDR_DISP_MODE, 8'h00, 1'b1, 1'b0, 3'h0);
      req_go(LCD_ADDR_DISP_MODE, 8'h01, 1'b1, 1'b1, 3'h4);
      req_go(LCD_ADDR_DISP_MODE, 8'h01, 1'b1, 1'b1, 3'h5);
      bus_rd(LCD_ADDR_DISP_MODE, 8'h10, 1'b1);
      chk("gate boost", 44'h1, 44'(boost));
      for (int i = 0; i < 22; i++) begin
         req_go(LCD_ADDR_DATA_FIRST + 16'(i), (i == 0) ? 8'h01 : (i == 21) ? 8'h03 : 8'h00, 1'b1, 1'b0, 3'h0);
      end
      bus_rd(LCD_ADDR_DATA_LAST, 8'h03, 1'b1);
      req_go(LCD_ADDR_CLK_SEL, 8'h00, 1'b1, 1'b0, 3'h0);
      req_go(LCD_ADDR_DISP_MODE, 8'hC4, 1'b1, 1'b0, 3'h0);
      frame_len(n);
      chk("static frame", 44'd128, 44'(n));
      chk("selected segments", 44'd2, 44'(sel_count));
      chk("segment 1 level", 44'(LCD_LVL_DESEL), 44'(seg_lvl[1]));
      req_go(LCD_ADDR_DISP_MODE, 8'h44, 1'b1, 1'b0, 3'h0);
      repeat (3) @(posedge clk_in);
      #1 chk("selected segments off", 44'd0, 44'(sel_count));
      for (int i = 0; i < 6; i++) begin
         req_go(LCD_ADDR_DISP_MODE, {5'h18, modes[i]}, 1'b1, 1'b0, 3'h0);
         frame_len(n);
         chk("mode frame", 44'(slices[i] * 128), 44'(n));
         if (i == 0) begin
            chk("upper commons", 44'hF, 44'(com_oe[7:4]));
            chk("fourth reference", 44'h1, 44'(quarter));
         end
      end
      for (int s = 0; s < 5; s++) begin
         req_go(LCD_ADDR_CLK_SEL, 8'(s << 4), 1'b1, 1'b0, 3'h0);
         frame_len(n);
         chk("source frame", 44'(srcper[s] * 16), 44'(n));
      end
      for (int d = 0; d < 6; d++) begin
         req_go(LCD_ADDR_CLK_SEL, 8'(d), 1'b1, 1'b0, 3'h0);
         frame_len(n);
         chk("divider frame", 44'(8 << (4 + d)), 44'(n));
      end
      req_go(LCD_ADDR_DISP_MODE, 8'h04, 1'b1, 1'b0, 3'h0);
      repeat (3) @(posedge clk_in);
      #1 chk("segment ground", 44'h0, 44'(seg_lvl));
      chk("common ground", 44'h0, 44'(com_lvl));
      report_and_stop();
   end
endmodule

bind lcd_ctrl lcd_ctrl_sva #(.NUM_SEG(NUM_SEG), .NUM_COM(NUM_COM)) u_sva (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .bus_hit_out(bus_hit_out),
   .segment_level_out(segment_level_out), .common_level_out(common_level_out), .common_oe_out(common_oe_out),
   .voltage_method_out(voltage_method_out), .gate_boost_en_out(gate_boost_en_out),
   .fourth_ref_sel_out(fourth_ref_sel_out), .frame_start_out(frame_start_out));
`default_nettype wire
